// [rtl/sps_pkg.sv]
// Shared constants and types of the two-wire serial port.
// Assumes an 8-bit register port with byte addresses and one system clock.
package sps_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_BUFFER = 8'h0C;
    localparam logic [7:0] ADDR_BAUD = 8'h10;
    localparam logic [7:0] ADDR_OWN = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h20;

    // Field positions
    localparam int CTRL1_RELEASE_BIT = 4;
    localparam int CTRL1_OVF_BIT = 6;
    localparam int CTRL2_STRETCH_BIT = 0;
    localparam int CTRL2_RSTART_BIT = 1;
    localparam int CTRL2_MREL_BIT = 2;
    localparam int STAT_FULL_BIT = 0;
    localparam int STAT_DIR_BIT = 2;
    localparam int STAT_MBUSY_BIT = 3;
    localparam int IRQ_XFER_BIT = 0;
    localparam int IRQ_COLL_BIT = 1;

    // Reset values and counts
    localparam logic [6:0] BAUD_RST = 7'h04;
    localparam logic [6:0] OWN_ADDR_RST = 7'h2A;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_RX, S_RX_ACK, S_TX, S_TX_ACK
    } sps_slave_t;

    typedef enum logic [2:0] {
        M_IDLE, M_REL, M_CNT1, M_SCLHI, M_CNT2, M_CNT3
    } sps_mst_t;

endpackage : sps_pkg

// [rtl/sps_sync.sv]
// Two-stage synchroniser for one pin level.
// Assumes the input is asynchronous to clk; output is the second stage only.
`timescale 1ns/10ps
module sps_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic din,
    output logic dout
);
    logic meta_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule : sps_sync

// [rtl/sps_baud_cnt.sv]
// Baud down-counter: loads a reload value, counts to zero, pulses on expiry.
// Assumes load is a one-cycle pulse from the same clock domain.
`timescale 1ns/10ps
module sps_baud_cnt #(
    parameter int WIDTH = 7
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] reload,
    output logic expired
);
    logic [WIDTH-1:0] cnt_r;
    logic run_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (load) begin
                cnt_r <= reload;
                run_r <= 1'b1;
            end else if (run_r) begin
                if (cnt_r == '0) begin
                    run_r <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 1'b1;
                end
            end
        end
    end
endmodule : sps_baud_cnt

// [rtl/sps_serial_port.sv]
// Two-wire serial port: slave receive/transmit after address match,
// and master repeated start with bus collision detection.
// Assumes open-drain pins resolved outside; oe high means pull low.
// Behaviour
// - Write-direction address match clears direction, buffers address, acknowledges.
// - Buffer full or overflow set at address byte: no acknowledge.
// - Every transferred byte raises transfer interrupt; software clears it.
// - Stretch enabled: hold SCL after each received byte until release bit set.
// - Read-direction match sets direction, buffers address, acks, always holds SCL.
// - Buffer write loads shift register; SCL held until release bit set.
// - Transmit bits shift out on SCL falling edges.
// - Master acknowledge latched on ninth rising edge; low means continue.
// - High acknowledge ends transfer; slave waits for new start.
// - Transmit interrupt flag set on ninth falling edge.
// - Repeated start: after SDA high, count baud, release SCL, sample SDA.
// - SDA low when SCL sampled high flags collision.
// - SDA high reloads counter; SDA falling meanwhile is no collision.
// - SCL falling before expiry, SDA not yet driven, flags collision.
// - SCL still high at expiry: drive SDA low, reload counter; SDA level is not checked.
// - Second expiry drives SCL low unconditionally, completing repeated start.
`timescale 1ns/10ps
module sps_serial_port #(
    parameter int BAUD_W = 7
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe,
    output logic irq
);
    logic scl_s, sda_s, scl_d_r, sda_d_r;
    logic scl_rise, scl_fall, start_det, stop_det;
    sps_pkg::sps_slave_t st_r;
    sps_pkg::sps_mst_t mst_r;
    logic [7:0] shift_reg_r, xfer_buffer_r;
    logic [3:0] bitcnt_r;
    logic slave_sda_r, nack_r, dir_r, buffer_full_flag_r, rx_overflow_flag_r;
    logic clock_release_bit_r, stretch_enable_r, m_scl_r, m_sda_r;
    logic [BAUD_W-1:0] baud_reload_value_r;
    logic [6:0] own_addr_r;
    logic [1:0] irq_stat_r, irq_en_r;
    logic addr_end, addr_hit, ev_addr_ack, ev_rx_end, ev_rx_ok, ev_hold;
    logic ev_tx_irq, ev_coll, buf_wr, buf_rd, tx_load, ctrl1_wr, ctrl2_wr;
    logic rstart_go, b_load, b_done;
    logic [1:0] irq_set, irq_clr;
    logic [7:0] rd_val;

    sps_sync u_scl_sync (.clk(clk), .sys_rst(sys_rst), .din(scl_in), .dout(scl_s));
    sps_sync u_sda_sync (.clk(clk), .sys_rst(sys_rst), .din(sda_in), .dout(sda_s));

    sps_baud_cnt #(.WIDTH(BAUD_W)) u_baud_counter (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(b_load),
        .reload(baud_reload_value_r),
        .expired(b_done)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // Register strobes
    assign buf_wr = reg_wr && reg_addr == sps_pkg::ADDR_BUFFER;
    assign buf_rd = reg_rd && reg_addr == sps_pkg::ADDR_BUFFER;
    assign ctrl1_wr = reg_wr && reg_addr == sps_pkg::ADDR_CTRL_ONE;
    assign ctrl2_wr = reg_wr && reg_addr == sps_pkg::ADDR_CTRL_TWO;
    // Only while the clock is held, so a late write cannot corrupt a byte
    assign tx_load = buf_wr && st_r == sps_pkg::S_TX && !clock_release_bit_r;

    // Slave events
    assign addr_end = st_r == sps_pkg::S_ADDR && scl_fall && bitcnt_r == sps_pkg::BITS_PER_BYTE;
    assign addr_hit = shift_reg_r[7:1] == own_addr_r;
    assign ev_addr_ack = addr_end && addr_hit && !(buffer_full_flag_r || rx_overflow_flag_r);
    assign ev_rx_end = st_r == sps_pkg::S_RX && scl_fall && bitcnt_r == sps_pkg::BITS_PER_BYTE;
    assign ev_rx_ok = ev_rx_end && !buffer_full_flag_r;
    assign ev_tx_irq = st_r == sps_pkg::S_TX_ACK && scl_fall;
    assign ev_hold = (st_r == sps_pkg::S_ADDR_ACK && scl_fall && dir_r)
        || (st_r == sps_pkg::S_RX_ACK && scl_fall && stretch_enable_r)
        || (ev_tx_irq && !nack_r);

    // Slave byte engine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= sps_pkg::S_IDLE;
            shift_reg_r <= 8'h00;
            xfer_buffer_r <= 8'h00;
            bitcnt_r <= 4'h0;
            slave_sda_r <= 1'b0;
            nack_r <= 1'b0;
            dir_r <= 1'b0;
        end else if (start_det) begin
            st_r <= sps_pkg::S_ADDR;
            bitcnt_r <= 4'h0;
            slave_sda_r <= 1'b0;
        end else if (stop_det) begin
            st_r <= sps_pkg::S_IDLE;
            slave_sda_r <= 1'b0;
        end else begin
            case (st_r)
                sps_pkg::S_ADDR, sps_pkg::S_RX: begin
                    if (scl_rise && bitcnt_r < sps_pkg::BITS_PER_BYTE) begin
                        shift_reg_r <= {shift_reg_r[6:0], sda_s};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end
                    if (ev_addr_ack) begin
                        xfer_buffer_r <= shift_reg_r;
                        dir_r <= shift_reg_r[0];
                        slave_sda_r <= 1'b1;
                        st_r <= sps_pkg::S_ADDR_ACK;
                    end else if (addr_end) begin
                        st_r <= sps_pkg::S_IDLE;
                    end else if (ev_rx_end) begin
                        bitcnt_r <= 4'h0;
                        st_r <= sps_pkg::S_RX_ACK;
                        if (ev_rx_ok) begin
                            xfer_buffer_r <= shift_reg_r;
                            slave_sda_r <= 1'b1;
                        end
                    end
                end
                sps_pkg::S_ADDR_ACK: begin
                    if (scl_fall) begin
                        slave_sda_r <= 1'b0;
                        bitcnt_r <= 4'h0;
                        st_r <= dir_r ? sps_pkg::S_TX : sps_pkg::S_RX;
                    end
                end
                sps_pkg::S_RX_ACK: begin
                    if (scl_fall) begin
                        slave_sda_r <= 1'b0;
                        st_r <= sps_pkg::S_RX;
                    end
                end
                sps_pkg::S_TX: begin
                    if (tx_load) begin
                        shift_reg_r <= reg_wdata;
                        xfer_buffer_r <= reg_wdata;
                        slave_sda_r <= ~reg_wdata[7];
                        bitcnt_r <= 4'h0;
                    end else if (scl_fall) begin
                        if (bitcnt_r == sps_pkg::LAST_TX_BIT) begin
                            slave_sda_r <= 1'b0;
                            nack_r <= 1'b0;
                            st_r <= sps_pkg::S_TX_ACK;
                        end else begin
                            shift_reg_r <= {shift_reg_r[6:0], 1'b0};
                            slave_sda_r <= ~shift_reg_r[6];
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end
                    end
                end
                sps_pkg::S_TX_ACK: begin
                    if (scl_rise) begin
                        nack_r <= sda_s;
                    end
                    if (scl_fall) begin
                        bitcnt_r <= 4'h0;
                        st_r <= nack_r ? sps_pkg::S_IDLE : sps_pkg::S_TX;
                    end
                end
                default: begin
                    st_r <= sps_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Buffer full: hardware set wins over the read that clears it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            buffer_full_flag_r <= 1'b0;
        end else if (ev_addr_ack || ev_rx_ok) begin
            buffer_full_flag_r <= 1'b1;
        end else if (buf_rd) begin
            buffer_full_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_overflow_flag_r <= 1'b0;
        end else if (ev_rx_end && buffer_full_flag_r) begin
            rx_overflow_flag_r <= 1'b1;
        end else if (ctrl1_wr) begin
            rx_overflow_flag_r <= reg_wdata[sps_pkg::CTRL1_OVF_BIT];
        end
    end

    // Hardware hold wins so a stretch is never skipped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clock_release_bit_r <= 1'b1;
        end else if (ev_hold) begin
            clock_release_bit_r <= 1'b0;
        end else if (ctrl1_wr) begin
            clock_release_bit_r <= reg_wdata[sps_pkg::CTRL1_RELEASE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stretch_enable_r <= 1'b0;
            baud_reload_value_r <= sps_pkg::BAUD_RST;
            own_addr_r <= sps_pkg::OWN_ADDR_RST;
            irq_en_r <= 2'h0;
        end else begin
            if (ctrl2_wr) begin
                stretch_enable_r <= reg_wdata[sps_pkg::CTRL2_STRETCH_BIT];
            end
            if (reg_wr && reg_addr == sps_pkg::ADDR_BAUD) begin
                baud_reload_value_r <= reg_wdata[BAUD_W-1:0];
            end
            if (reg_wr && reg_addr == sps_pkg::ADDR_OWN) begin
                own_addr_r <= reg_wdata[6:0];
            end
            if (reg_wr && reg_addr == sps_pkg::ADDR_IRQ_EN) begin
                irq_en_r <= reg_wdata[1:0];
            end
        end
    end

    // Master repeated start
    assign rstart_go = ctrl2_wr && reg_wdata[sps_pkg::CTRL2_RSTART_BIT] && mst_r == sps_pkg::M_IDLE;
    assign ev_coll = (mst_r == sps_pkg::M_SCLHI && scl_s && !sda_s)
        || (mst_r == sps_pkg::M_CNT2 && !scl_s);
    assign b_load = (mst_r == sps_pkg::M_REL && sda_s)
        || (mst_r == sps_pkg::M_SCLHI && scl_s && sda_s)
        || (mst_r == sps_pkg::M_CNT2 && scl_s && b_done);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mst_r <= sps_pkg::M_IDLE;
            m_scl_r <= 1'b0;
            m_sda_r <= 1'b0;
        end else if (ev_coll) begin
            mst_r <= sps_pkg::M_IDLE;
            m_scl_r <= 1'b0;
            m_sda_r <= 1'b0;
        end else begin
            case (mst_r)
                sps_pkg::M_IDLE: begin
                    if (rstart_go) begin
                        m_scl_r <= 1'b1;
                        m_sda_r <= 1'b0;
                        mst_r <= sps_pkg::M_REL;
                    end else if (ctrl2_wr && reg_wdata[sps_pkg::CTRL2_MREL_BIT]) begin
                        m_scl_r <= 1'b0;
                        m_sda_r <= 1'b0;
                    end
                end
                sps_pkg::M_REL: begin
                    if (sda_s) begin
                        mst_r <= sps_pkg::M_CNT1;
                    end
                end
                sps_pkg::M_CNT1: begin
                    if (b_done) begin
                        m_scl_r <= 1'b0;
                        mst_r <= sps_pkg::M_SCLHI;
                    end
                end
                sps_pkg::M_SCLHI: begin
                    if (scl_s) begin
                        mst_r <= sps_pkg::M_CNT2;
                    end
                end
                sps_pkg::M_CNT2: begin
                    if (b_done) begin
                        m_sda_r <= 1'b1;
                        mst_r <= sps_pkg::M_CNT3;
                    end
                end
                sps_pkg::M_CNT3: begin
                    if (b_done) begin
                        m_scl_r <= 1'b1;
                        mst_r <= sps_pkg::M_IDLE;
                    end
                end
                default: begin
                    mst_r <= sps_pkg::M_IDLE;
                end
            endcase
        end
    end

    // Sticky interrupt status; a set in the clearing cycle survives
    assign irq_set = {ev_coll, ev_addr_ack || ev_rx_end || ev_tx_irq};
    assign irq_clr = (reg_wr && reg_addr == sps_pkg::ADDR_IRQ_CLR) ? reg_wdata[1:0] : 2'h0;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_stat_r <= 2'h0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    always_comb begin
        rd_val = 8'h00;
        if (reg_addr == sps_pkg::ADDR_CTRL_ONE) begin
            rd_val[sps_pkg::CTRL1_RELEASE_BIT] = clock_release_bit_r;
            rd_val[sps_pkg::CTRL1_OVF_BIT] = rx_overflow_flag_r;
        end else if (reg_addr == sps_pkg::ADDR_CTRL_TWO) begin
            rd_val[sps_pkg::CTRL2_STRETCH_BIT] = stretch_enable_r;
        end else if (reg_addr == sps_pkg::ADDR_STATUS) begin
            rd_val[sps_pkg::STAT_FULL_BIT] = buffer_full_flag_r;
            rd_val[sps_pkg::STAT_DIR_BIT] = dir_r;
            rd_val[sps_pkg::STAT_MBUSY_BIT] = mst_r != sps_pkg::M_IDLE;
        end else if (reg_addr == sps_pkg::ADDR_BUFFER) begin
            rd_val = xfer_buffer_r;
        end else if (reg_addr == sps_pkg::ADDR_BAUD) begin
            rd_val[BAUD_W-1:0] = baud_reload_value_r;
        end else if (reg_addr == sps_pkg::ADDR_OWN) begin
            rd_val[6:0] = own_addr_r;
        end else if (reg_addr == sps_pkg::ADDR_IRQ_STAT) begin
            rd_val[1:0] = irq_stat_r;
        end else if (reg_addr == sps_pkg::ADDR_IRQ_EN) begin
            rd_val[1:0] = irq_en_r;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            irq <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rd_val : 8'h00;
            irq <= |(irq_stat_r & irq_en_r);
            scl_oe <= ~clock_release_bit_r | m_scl_r;
            sda_oe <= slave_sda_r | m_sda_r;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    property p_addr_ack;
        @(posedge clk) disable iff (sys_rst)
        (addr_end && addr_hit && !buffer_full_flag_r && !rx_overflow_flag_r && !shift_reg_r[0])
        |=> (slave_sda_r && !dir_r) ##1 sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address ack missing");

    property p_no_ack_ovf;
        @(posedge clk) disable iff (sys_rst)
        (addr_end && (buffer_full_flag_r || rx_overflow_flag_r)) |=> !slave_sda_r;
    endproperty
    a_no_ack_ovf: assert property (p_no_ack_ovf) else $error("ack given on overflow");

    property p_rx_irq;
        @(posedge clk) disable iff (sys_rst)
        ev_rx_end |=> irq_stat_r[sps_pkg::IRQ_XFER_BIT];
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("byte interrupt not set");

    property p_rx_stretch;
        @(posedge clk) disable iff (sys_rst)
        (st_r == sps_pkg::S_RX_ACK && scl_fall && stretch_enable_r && !start_det && !stop_det)
        |=> !clock_release_bit_r ##1 scl_oe;
    endproperty
    a_rx_stretch: assert property (p_rx_stretch) else $error("no stretch after rx");

    property p_tx_hold;
        @(posedge clk) disable iff (sys_rst)
        (st_r == sps_pkg::S_ADDR_ACK && scl_fall && dir_r && !start_det && !stop_det)
        |=> (st_r == sps_pkg::S_TX && !clock_release_bit_r);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("read address not held");

    property p_tx_load;
        @(posedge clk) disable iff (sys_rst)
        (tx_load && !start_det && !stop_det) |=> shift_reg_r == $past(reg_wdata);
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("shift register not loaded");

    property p_nack_end;
        @(posedge clk) disable iff (sys_rst)
        (ev_tx_irq && nack_r && !start_det && !stop_det)
        |=> st_r == sps_pkg::S_IDLE && irq_stat_r[sps_pkg::IRQ_XFER_BIT];
    endproperty
    a_nack_end: assert property (p_nack_end) else $error("nack did not end transfer");

    property p_coll_sda;
        @(posedge clk) disable iff (sys_rst)
        (mst_r == sps_pkg::M_SCLHI && scl_s && !sda_s)
        |=> (irq_stat_r[sps_pkg::IRQ_COLL_BIT] && mst_r == sps_pkg::M_IDLE);
    endproperty
    a_coll_sda: assert property (p_coll_sda) else $error("collision on sda missed");

    property p_coll_scl;
        @(posedge clk) disable iff (sys_rst)
        (mst_r == sps_pkg::M_CNT2 && !scl_s) |=> ##1 (!scl_oe && !sda_oe) || irq_stat_r[1];
    endproperty
    a_coll_scl: assert property (p_coll_scl) else $error("early scl fall missed");

    property p_rs_done;
        @(posedge clk) disable iff (sys_rst)
        (mst_r == sps_pkg::M_CNT3 && b_done) |=> ##1 scl_oe;
    endproperty
    a_rs_done: assert property (p_rs_done) else $error("scl not driven at end");

endmodule : sps_serial_port

// [tb/sps_host_mdl.sv]
// Behavioural two-wire bus master facing the serial port's pins.
// Assumes pull-ups on both lines; the device drives only through its oe outputs.
`timescale 1ns/10ps
module sps_host_mdl (
    input wire logic clk,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_oe,
    output logic scl,
    output logic sda
);
    logic scl_low_r = 1'b0;
    logic sda_low_r = 1'b0;
    // Clock stretches that outlasted the wait bound
    int stalls = 0;
    // Wired-and of both parties; a released line floats high
    assign scl = ~(scl_low_r | dev_scl_oe);
    assign sda = ~(sda_low_r | dev_sda_oe);
    task automatic half;
        repeat (8) @(posedge clk);
    endtask : half
    task automatic pulse(output logic seen);
        int n;
        n = 0;
        scl_low_r <= 1'b0;
        while (scl !== 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n == 5000) begin
            stalls++;
        end
        half();
        seen = sda;
        scl_low_r <= 1'b1;
        half();
    endtask : pulse
    task automatic start;
        sda_low_r <= 1'b0;
        half();
        scl_low_r <= 1'b0;
        half();
        sda_low_r <= 1'b1;
        half();
        scl_low_r <= 1'b1;
        half();
    endtask : start
    // Nine clocks; bit 0 is the acknowledge slot
    task automatic xfer(input logic [8:0] out, output logic [8:0] got);
        for (int i = 8; i >= 0; i--) begin
            sda_low_r <= ~out[i];
            pulse(got[i]);
        end
        sda_low_r <= 1'b0;
    endtask : xfer
    task automatic stop;
        sda_low_r <= 1'b1;
        half();
        scl_low_r <= 1'b0;
        half();
        sda_low_r <= 1'b0;
        half();
    endtask : stop
endmodule : sps_host_mdl

// [tb/tb_sps_serial_port.sv]
// Self-checking bench of the serial port with a bus master model on the pins.
// Assumes a 100 MHz clock and the register map of the shared package.
`timescale 1ns/10ps
module tb_sps_serial_port;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic scl_out, scl_oe, sda_out, sda_oe, irq, scl, sda;
    logic [8:0] got;
    logic [7:0] d;
    int miscompares = 0;
    int checks_done = 0;
    sps_serial_port #(.BAUD_W(7)) uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scl_in(scl), .sda_in(sda), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
        .sda_oe(sda_oe), .irq(irq));
    sps_host_mdl mst (.clk(clk), .dev_scl_oe(scl_oe), .dev_sda_oe(sda_oe), .scl(scl),
        .sda(sda));
    initial forever #5 clk = ~clk;
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        chk(what, {1'b0, exp}, {1'b0, d & m});
    endtask : rchk
    // Bounded wait on one of the two pull-down enables
    task automatic wait_oe(input logic on_sda, input logic val);
        int n;
        n = 0;
        while (((on_sda ? sda_oe : scl_oe) !== val) && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 2000) begin
            miscompares++;
            results();
        end
    endtask : wait_oe
    task automatic t_regs;
        rchk("baud", sps_pkg::ADDR_BAUD, 8'h7F, {1'b0, sps_pkg::BAUD_RST});
        rchk("own", sps_pkg::ADDR_OWN, 8'h7F, {1'b0, sps_pkg::OWN_ADDR_RST});
        rchk("unmapped", 8'h30, 8'hFF, 8'h00);
        chk("pin drive", 9'h000, {7'h00, scl_out, sda_out});
        wr(sps_pkg::ADDR_IRQ_EN, 8'h03);
        wr(sps_pkg::ADDR_CTRL_TWO, 8'h01);
        $display("regs done");
    endtask : t_regs
    task automatic t_rx;
        mst.start();
        mst.xfer({sps_pkg::OWN_ADDR_RST, 2'b01}, got);
        chk("addr ack", 9'h000, {8'h00, got[0]});
        rchk("rx status", sps_pkg::ADDR_STATUS, 8'h05, 8'h01);
        rchk("rx addr", sps_pkg::ADDR_BUFFER, 8'hFF, {sps_pkg::OWN_ADDR_RST, 1'b0});
        wr(sps_pkg::ADDR_IRQ_CLR, 8'h01);
        wr(sps_pkg::ADDR_CTRL_ONE, 8'h10);
        mst.xfer({8'h5A, 1'b1}, got);
        repeat (6) @(posedge clk);
        chk("rx hold", 9'h001, {8'h00, scl_oe});
        chk("irq", 9'h001, {8'h00, irq});
        rchk("rx data", sps_pkg::ADDR_BUFFER, 8'hFF, 8'h5A);
        wr(sps_pkg::ADDR_CTRL_ONE, 8'h10);
        wait_oe(1'b0, 1'b0);
        mst.stop();
        $display("rx done");
    endtask : t_rx
    task automatic t_full;
        mst.start();
        mst.xfer({sps_pkg::OWN_ADDR_RST, 2'b01}, got);
        wr(sps_pkg::ADDR_CTRL_ONE, 8'h10);
        mst.stop();
        mst.start();
        mst.xfer({sps_pkg::OWN_ADDR_RST, 2'b01}, got);
        chk("full nack", 9'h001, {8'h00, got[0]});
        mst.stop();
        rchk("full buf", sps_pkg::ADDR_BUFFER, 8'hFF, {sps_pkg::OWN_ADDR_RST, 1'b0});
        $display("full done");
    endtask : t_full
    task automatic t_tx;
        mst.start();
        mst.xfer({sps_pkg::OWN_ADDR_RST, 2'b11}, got);
        chk("rd ack", 9'h000, {8'h00, got[0]});
        repeat (6) @(posedge clk);
        chk("tx hold", 9'h001, {8'h00, scl_oe});
        rchk("dir", sps_pkg::ADDR_STATUS, 8'h04, 8'h04);
        wr(sps_pkg::ADDR_IRQ_CLR, 8'h03);
        wr(sps_pkg::ADDR_BUFFER, 8'hA5);
        wr(sps_pkg::ADDR_CTRL_ONE, 8'h10);
        mst.xfer(9'h1FF, got);
        chk("tx byte", {8'hA5, 1'b1}, got);
        rchk("tx irq", sps_pkg::ADDR_IRQ_STAT, 8'h01, 8'h01);
        chk("tx idle", 9'h000, {8'h00, scl_oe});
        mst.stop();
        $display("tx done");
    endtask : t_tx
    task automatic t_rstart;
        wr(sps_pkg::ADDR_IRQ_CLR, 8'h03);
        wr(sps_pkg::ADDR_CTRL_TWO, 8'h03);
        wait_oe(1'b0, 1'b1);
        wait_oe(1'b0, 1'b0);
        // Another master holds SDA low as SCL is let go
        mst.sda_low_r <= 1'b1;
        repeat (20) @(posedge clk);
        rchk("coll sda", sps_pkg::ADDR_IRQ_STAT, 8'h02, 8'h02);
        mst.sda_low_r <= 1'b0;
        wr(sps_pkg::ADDR_IRQ_CLR, 8'h02);
        wr(sps_pkg::ADDR_CTRL_TWO, 8'h03);
        wait_oe(1'b0, 1'b1);
        wait_oe(1'b0, 1'b0);
        // SCL must be seen high first, then pulled down inside the count
        repeat (3) @(posedge clk);
        mst.scl_low_r <= 1'b1;
        repeat (20) @(posedge clk);
        rchk("coll", sps_pkg::ADDR_IRQ_STAT, 8'h02, 8'h02);
        rchk("busy", sps_pkg::ADDR_STATUS, 8'h08, 8'h00);
        mst.scl_low_r <= 1'b0;
        wr(sps_pkg::ADDR_IRQ_CLR, 8'h02);
        wr(sps_pkg::ADDR_CTRL_TWO, 8'h03);
        wait_oe(1'b0, 1'b1);
        wait_oe(1'b0, 1'b0);
        wait_oe(1'b1, 1'b1);
        wait_oe(1'b0, 1'b1);
        rchk("no coll", sps_pkg::ADDR_IRQ_STAT, 8'h02, 8'h00);
        wr(sps_pkg::ADDR_CTRL_TWO, 8'h05);
        wait_oe(1'b1, 1'b0);
        $display("rstart done");
    endtask : t_rstart
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_rx();
        t_full();
        t_tx();
        t_rstart();
        chk("stretch wait", 9'h000, mst.stalls[8:0]);
        results();
    end
endmodule : tb_sps_serial_port
